/* shared/rsc_defs.svh */
// Register offsets, field positions, reset values and message codes
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

`define RSC_OFS_CTRL       6'h00
`define RSC_OFS_PF_SENSE   6'h04
`define RSC_OFS_REAL_PWR   6'h08
`define RSC_OFS_APP_PWR    6'h0c
`define RSC_OFS_REACT_PWR  6'h10
`define RSC_OFS_FIELD_CUR  6'h14
`define RSC_OFS_ENG_SPEED  6'h18
`define RSC_OFS_FIELD_VOLT 6'h1c
`define RSC_OFS_REG_TEMP   6'h20
`define RSC_OFS_SW_DATE    6'h24
`define RSC_OFS_REVISION   6'h28
`define RSC_OFS_OP_STATUS  6'h2c
`define RSC_OFS_FRAME_SIZE 6'h30
`define RSC_OFS_ALARM_DIS  6'h34
`define RSC_OFS_ALARM_STAT 6'h38

`define RSC_ID_PWR_SENSE   16'hff30
`define RSC_ID_FIELD_SPEED 16'hff2a
`define RSC_ID_SW_VERSION  16'hff5a
`define RSC_ID_OP_STATUS   16'hff5b

`define RSC_BYTE_UNUSED    8'hff
`define RSC_PF_LAGGING     8'h00
`define RSC_PF_LEADING     8'h01
`define RSC_DEV_MODE_ON    8'h01
`define RSC_DEV_MODE_HIST  8'h07
`define RSC_DEV_MODE_DIAGE 8'h0e

`define RSC_IND_OK         2'h0
`define RSC_IND_ALARM      2'h1
`define RSC_IND_FAULT      2'h2
`define RSC_IND_DISABLED   2'h3

`define RSC_OP_EXC_BIT     0
`define RSC_OP_PMG_BIT     1
`define RSC_OP_SINGLE_BIT  2
`define RSC_OP_VR_LSB      4
`define RSC_OP_MODE_LSB    8
`define RSC_OP_DEV_LSB     16
`define RSC_DEV_MODE_RST   8'h01

`endif

/* shared/rsc_pkg.sv */
// Types shared by the regulator status payload framer
package rsc_pkg;

  typedef struct packed {
    logic [15:0] id;
    logic [63:0] data;
  } rsc_frame_t;

  typedef enum logic [1:0] {
    RSC_TX_IDLE = 2'b01,
    RSC_TX_SEND = 2'b10
  } rsc_tx_state_t;

  typedef enum logic [3:0] {
    RSC_MSG_PWR   = 4'b0001,
    RSC_MSG_FIELD = 4'b0010,
    RSC_MSG_VER   = 4'b0100,
    RSC_MSG_OPS   = 4'b1000
  } rsc_msg_t;

  typedef struct packed {
    logic [7:0] year_hi;
    logic [7:0] year_lo;
    logic [7:0] month;
    logic [7:0] day;
  } rsc_bcd_date_t;

endpackage

/* design/rsc_alarm_enc.sv */
// Two-bit alarm and fault indicator encoder
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_alarm_enc #(
  parameter int N = 11
) (
  input  wire logic [N-1:0]   alarm_in,
  input  wire logic [N-1:0]   fault_in,
  input  wire logic [N-1:0]   disable_in,
  output logic      [2*N-1:0] code_out
);
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_ind
      // indicator code
      // Disabled hides any condition; fault outranks alarm
      assign code_out[2*g+1:2*g] = disable_in[g] ? `RSC_IND_DISABLED :
                                   fault_in[g]   ? `RSC_IND_FAULT    :
                                   alarm_in[g]   ? `RSC_IND_ALARM    : `RSC_IND_OK;
    end
  endgenerate
endmodule

/* design/rsc_bcd_date.sv */
// Binary date to packed two-digit decimal bytes
`timescale 1ns/1ps
module rsc_bcd_date (
  input  wire logic [13:0]           year_in,
  input  wire logic [3:0]            month_in,
  input  wire logic [4:0]            day_in,
  output rsc_pkg::rsc_bcd_date_t     date_out
);
  function automatic logic [7:0] to_bcd(input logic [13:0] v);
    logic [13:0] t;
    logic [13:0] u;
    t = v / 14'd10;
    u = v % 14'd10;
    // Values above 99 keep only four bits of the tens digit; software keeps each field in range
    to_bcd = {t[3:0], u[3:0]};
  endfunction

  logic [13:0] century;
  logic [13:0] yy;
  assign century = year_in / 14'd100;
  assign yy      = year_in % 14'd100;

  assign date_out.year_lo = to_bcd(yy);
  assign date_out.year_hi = to_bcd(century);
  assign date_out.month   = to_bcd({10'h000, month_in});
  assign date_out.day     = to_bcd({9'h000, day_in});
endmodule

/* design/rsc_framer.sv */
// Payload framer for four periodic regulator status broadcasts
//
// Overview of operation
// - Terminal power message uses identifier ff30, format 255, specific 48, eight bytes.
// - Power message byte 0 is factor direction 00 lag 01 lead; byte 1 ff.
// - Real power 16 bits, low byte 2, high byte 3, one watt each.
// - Apparent power 16 bits, low byte 4, high byte 5, one VA each.
// - Reactive power 16 bits, low byte 6, high byte 7, one VAR each.
// - Field and speed message uses identifier ff2a, format 255, specific 42.
// - Field current in bytes 0 low, 1 high, one milliampere each.
// - Engine speed in bytes 2 low, 3 high, one rpm each.
// - Field voltage in bytes 4 low, 5 high, tenth volt each.
// - Regulator temperature signed in bytes 6 low, 7 high, one degree each.
// - Software version message uses identifier ff5a, format 255, specific 90.
// - Year as decimal digit pairs: last two in byte 0, first two byte 1.
// - Month in byte 2, day in byte 3, each packed decimal.
// - Bytes 4-6 carry revisions; byte 7 ff unless diagnostic mode.
// - Operating status message uses identifier ff5b, format 255, specific 91.
// - Status byte 0 is excitation: 00 off, 01 on.
// - Frame size 16 bits, low byte 1, high byte 2.
// - Byte 3 power source, 01 magnet generator; byte 4 current sensing phases.
// - Byte 5 regulator state: run, excitation off, alarm, fault.
// - Byte 6 regulation mode: three-phase voltage, field current, single-phase voltage.
// - Byte 7 device mode: 01 normal, 07 history, others diagnostic (code treats only 00, 02-06 and 0e as diagnostic).
// - Each indicator is two bits: ok, alarm, fault, disabled.
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_framer #(
  parameter int N_IND = 11
) (
  input  wire logic                  clk_sys_in,
  input  wire logic                  resetn_in,
  input  wire logic [5:0]            avs_address_in,
  input  wire logic                  avs_read_in,
  input  wire logic                  avs_write_in,
  input  wire logic [31:0]           avs_writedata_in,
  input  wire logic [3:0]            avs_byteenable_in,
  output logic      [31:0]           avs_readdata_out,
  output logic                       avs_waitrequest_out,
  input  wire logic [N_IND-1:0]      alarm_active_in,
  input  wire logic [N_IND-1:0]      fault_active_in,
  output logic      [2*N_IND-1:0]    alarm_status_out,
  output rsc_pkg::rsc_frame_t        msg_frame_out,
  output logic                       msg_valid_out,
  input  wire logic                  msg_ready_in
);
  logic [31:0]           pf_sense_reg;
  logic [31:0]           real_pwr_reg;
  logic [31:0]           app_pwr_reg;
  logic [31:0]           react_pwr_reg;
  logic [31:0]           field_cur_reg;
  logic [31:0]           eng_speed_reg;
  logic [31:0]           field_volt_reg;
  logic [31:0]           reg_temp_reg;
  logic [31:0]           sw_date_reg;
  logic [31:0]           revision_reg;
  logic [31:0]           op_status_reg;
  logic [31:0]           frame_size_reg;
  logic [31:0]           alarm_dis_reg;
  logic [3:0]            pending_reg;
  logic [3:0]            pending_next;
  logic [63:0]           snap_reg [4];
  rsc_pkg::rsc_tx_state_t tx_state_reg;
  rsc_pkg::rsc_bcd_date_t bcd_date;
  logic [2*N_IND-1:0]    alarm_code;
  logic                  bus_take;
  logic                  wr_take;
  logic [3:0]            req;
  logic [3:0]            launch;
  logic [63:0]           pay_pwr;
  logic [63:0]           pay_field;
  logic [63:0]           pay_ver;
  logic [63:0]           pay_ops;
  logic [31:0]           rd_mux;
  logic [7:0]            dev_mode;

  function automatic logic is_diag(input logic [7:0] m);
    is_diag = (m == 8'h00) || (m >= 8'h02 && m <= 8'h06) || (m == `RSC_DEV_MODE_DIAGE);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  rsc_bcd_date u_bcd (
    .year_in  (sw_date_reg[13:0]),
    .month_in (sw_date_reg[19:16]),
    .day_in   (sw_date_reg[28:24]),
    .date_out (bcd_date)
  );

  rsc_alarm_enc #(.N(N_IND)) u_alarm (
    .alarm_in   (alarm_active_in),
    .fault_in   (fault_active_in),
    .disable_in (alarm_dis_reg[N_IND-1:0]),
    .code_out   (alarm_code)
  );

  // Bus answers one cycle after the request appears
  assign bus_take = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
  assign wr_take  = avs_write_in && !avs_waitrequest_out;
  assign dev_mode = op_status_reg[`RSC_OP_DEV_LSB +: 8];

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if (bus_take) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !(avs_read_in || avs_write_in);
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address_in == `RSC_OFS_CTRL) begin
      rd_mux = {28'h0000000, pending_reg};
    end else if (avs_address_in == `RSC_OFS_PF_SENSE) begin
      rd_mux = pf_sense_reg;
    end else if (avs_address_in == `RSC_OFS_REAL_PWR) begin
      rd_mux = real_pwr_reg;
    end else if (avs_address_in == `RSC_OFS_APP_PWR) begin
      rd_mux = app_pwr_reg;
    end else if (avs_address_in == `RSC_OFS_REACT_PWR) begin
      rd_mux = react_pwr_reg;
    end else if (avs_address_in == `RSC_OFS_FIELD_CUR) begin
      rd_mux = field_cur_reg;
    end else if (avs_address_in == `RSC_OFS_ENG_SPEED) begin
      rd_mux = eng_speed_reg;
    end else if (avs_address_in == `RSC_OFS_FIELD_VOLT) begin
      rd_mux = field_volt_reg;
    end else if (avs_address_in == `RSC_OFS_REG_TEMP) begin
      rd_mux = reg_temp_reg;
    end else if (avs_address_in == `RSC_OFS_SW_DATE) begin
      rd_mux = sw_date_reg;
    end else if (avs_address_in == `RSC_OFS_REVISION) begin
      rd_mux = revision_reg;
    end else if (avs_address_in == `RSC_OFS_OP_STATUS) begin
      rd_mux = op_status_reg;
    end else if (avs_address_in == `RSC_OFS_FRAME_SIZE) begin
      rd_mux = frame_size_reg;
    end else if (avs_address_in == `RSC_OFS_ALARM_DIS) begin
      rd_mux = alarm_dis_reg;
    end else if (avs_address_in == `RSC_OFS_ALARM_STAT) begin
      rd_mux = {{(32-2*N_IND){1'b0}}, alarm_status_out};
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && avs_waitrequest_out) begin
      avs_readdata_out <= rd_mux;
    end
  end

  // Field registers hold only the widths that reach a payload
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pf_sense_reg   <= 32'h0000_0000;
      real_pwr_reg   <= 32'h0000_0000;
      app_pwr_reg    <= 32'h0000_0000;
      react_pwr_reg  <= 32'h0000_0000;
      field_cur_reg  <= 32'h0000_0000;
      eng_speed_reg  <= 32'h0000_0000;
      field_volt_reg <= 32'h0000_0000;
      reg_temp_reg   <= 32'h0000_0000;
      sw_date_reg    <= 32'h0000_0000;
      revision_reg   <= 32'h0000_0000;
      op_status_reg  <= {8'h00, `RSC_DEV_MODE_RST, 16'h0000};
      frame_size_reg <= 32'h0000_0000;
      alarm_dis_reg  <= 32'h0000_0000;
    end else if (wr_take) begin
      if (avs_address_in == `RSC_OFS_PF_SENSE) begin
        pf_sense_reg <= merge(pf_sense_reg, avs_writedata_in, avs_byteenable_in) & 32'h1;
      end else if (avs_address_in == `RSC_OFS_REAL_PWR) begin
        real_pwr_reg <= merge(real_pwr_reg, avs_writedata_in, avs_byteenable_in) & 32'hffff;
      end else if (avs_address_in == `RSC_OFS_APP_PWR) begin
        app_pwr_reg <= merge(app_pwr_reg, avs_writedata_in, avs_byteenable_in) & 32'hffff;
      end else if (avs_address_in == `RSC_OFS_REACT_PWR) begin
        react_pwr_reg <= merge(react_pwr_reg, avs_writedata_in, avs_byteenable_in) & 32'hffff;
      end else if (avs_address_in == `RSC_OFS_FIELD_CUR) begin
        field_cur_reg <= merge(field_cur_reg, avs_writedata_in, avs_byteenable_in) & 32'hffff;
      end else if (avs_address_in == `RSC_OFS_ENG_SPEED) begin
        eng_speed_reg <= merge(eng_speed_reg, avs_writedata_in, avs_byteenable_in) & 32'hffff;
      end else if (avs_address_in == `RSC_OFS_FIELD_VOLT) begin
        field_volt_reg <= merge(field_volt_reg, avs_writedata_in, avs_byteenable_in) & 32'hffff;
      end else if (avs_address_in == `RSC_OFS_REG_TEMP) begin
        reg_temp_reg <= merge(reg_temp_reg, avs_writedata_in, avs_byteenable_in) & 32'hffff;
      end else if (avs_address_in == `RSC_OFS_SW_DATE) begin
        sw_date_reg <= merge(sw_date_reg, avs_writedata_in, avs_byteenable_in) & 32'h1f0f_3fff;
      end else if (avs_address_in == `RSC_OFS_REVISION) begin
        revision_reg <= merge(revision_reg, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == `RSC_OFS_OP_STATUS) begin
        op_status_reg <= merge(op_status_reg, avs_writedata_in, avs_byteenable_in) & 32'h00ff_0337;
      end else if (avs_address_in == `RSC_OFS_FRAME_SIZE) begin
        frame_size_reg <= merge(frame_size_reg, avs_writedata_in, avs_byteenable_in) & 32'hffff;
      end else if (avs_address_in == `RSC_OFS_ALARM_DIS) begin
        alarm_dis_reg <= merge(alarm_dis_reg, avs_writedata_in, avs_byteenable_in)
                         & {{(32-N_IND){1'b0}}, {N_IND{1'b1}}};
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      alarm_status_out <= '0;
    end else begin
      alarm_status_out <= alarm_code;
    end
  end

  assign pay_pwr = {react_pwr_reg[15:0], app_pwr_reg[15:0], real_pwr_reg[15:0],
                    `RSC_BYTE_UNUSED,
                    pf_sense_reg[0] ? `RSC_PF_LEADING : `RSC_PF_LAGGING};
  assign pay_field = {reg_temp_reg[15:0], field_volt_reg[15:0], eng_speed_reg[15:0],
                      field_cur_reg[15:0]};
  assign pay_ver = {is_diag(dev_mode) ? revision_reg[31:24] : `RSC_BYTE_UNUSED,
                    revision_reg[23:0], bcd_date.day, bcd_date.month,
                    bcd_date.year_hi, bcd_date.year_lo};
  assign pay_ops = {dev_mode,
                    6'h00, op_status_reg[`RSC_OP_MODE_LSB +: 2],
                    6'h00, op_status_reg[`RSC_OP_VR_LSB +: 2],
                    7'h00, op_status_reg[`RSC_OP_SINGLE_BIT],
                    7'h00, op_status_reg[`RSC_OP_PMG_BIT],
                    frame_size_reg[15:0],
                    7'h00, op_status_reg[`RSC_OP_EXC_BIT]};

  assign req = (wr_take && avs_address_in == `RSC_OFS_CTRL && avs_byteenable_in[0])
               ? avs_writedata_in[3:0] : 4'h0;

  // one-edge snapshot per request
  // Field writes and the request are separate accesses, so no torn words
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 4; i++) begin
        snap_reg[i] <= 64'hffff_ffff_ffff_ffff;
      end
    end else begin
      if (req[0]) begin
        snap_reg[0] <= pay_pwr;
      end
      if (req[1]) begin
        snap_reg[1] <= pay_field;
      end
      if (req[2]) begin
        snap_reg[2] <= pay_ver;
      end
      if (req[3]) begin
        snap_reg[3] <= pay_ops;
      end
    end
  end

  // Lowest pending message goes first
  always_comb begin
    launch = 4'h0;
    if (tx_state_reg == rsc_pkg::RSC_TX_IDLE || msg_ready_in) begin
      if (pending_reg[0]) begin
        launch = rsc_pkg::RSC_MSG_PWR;
      end else if (pending_reg[1]) begin
        launch = rsc_pkg::RSC_MSG_FIELD;
      end else if (pending_reg[2]) begin
        launch = rsc_pkg::RSC_MSG_VER;
      end else if (pending_reg[3]) begin
        launch = rsc_pkg::RSC_MSG_OPS;
      end
    end
  end

  // New request wins over the launch that clears it
  assign pending_next = (pending_reg & ~launch) | req;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pending_reg <= 4'h0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_state_reg  <= rsc_pkg::RSC_TX_IDLE;
      msg_valid_out <= 1'b0;
      msg_frame_out <= '0;
    end else begin
      case (tx_state_reg)
        rsc_pkg::RSC_TX_IDLE: begin
          if (launch != 4'h0) begin
            tx_state_reg  <= rsc_pkg::RSC_TX_SEND;
            msg_valid_out <= 1'b1;
          end
        end
        rsc_pkg::RSC_TX_SEND: begin
          if (msg_ready_in && launch == 4'h0) begin
            tx_state_reg  <= rsc_pkg::RSC_TX_IDLE;
            msg_valid_out <= 1'b0;
          end
        end
        default: begin
          tx_state_reg  <= rsc_pkg::RSC_TX_IDLE;
          msg_valid_out <= 1'b0;
        end
      endcase
      if (launch[0]) begin
        msg_frame_out <= '{id: `RSC_ID_PWR_SENSE, data: snap_reg[0]};
      end else if (launch[1]) begin
        msg_frame_out <= '{id: `RSC_ID_FIELD_SPEED, data: snap_reg[1]};
      end else if (launch[2]) begin
        msg_frame_out <= '{id: `RSC_ID_SW_VERSION, data: snap_reg[2]};
      end else if (launch[3]) begin
        msg_frame_out <= '{id: `RSC_ID_OP_STATUS, data: snap_reg[3]};
      end
    end
  end

  AST_PWR_BYTES: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    msg_valid_out && msg_frame_out.id == `RSC_ID_PWR_SENSE |->
      msg_frame_out.data[15:8] == 8'hff && msg_frame_out.data[7:1] == 7'h00)
    else $error("power message byte 0 or 1 wrong");
  AST_ID_LEGAL: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    msg_valid_out |-> msg_frame_out.id inside {`RSC_ID_PWR_SENSE, `RSC_ID_FIELD_SPEED,
                                               `RSC_ID_SW_VERSION, `RSC_ID_OP_STATUS})
    else $error("unknown message identifier");
  AST_HOLD: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    msg_valid_out && !msg_ready_in |=> msg_valid_out && $stable(msg_frame_out))
    else $error("frame changed before it was taken");
  AST_SNAP: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    req[1] |=> snap_reg[1] == {$past(reg_temp_reg[15:0]), $past(field_volt_reg[15:0]),
                               $past(eng_speed_reg[15:0]), $past(field_cur_reg[15:0])})
    else $error("snapshot does not match its sample");
  AST_SEND_SOON: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    pending_reg != 4'h0 && !msg_valid_out |=> msg_valid_out)
    else $error("pending message not launched");
  AST_OPS_CODES: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    msg_valid_out && msg_frame_out.id == `RSC_ID_OP_STATUS |->
      msg_frame_out.data[47:40] <= 8'h03 && msg_frame_out.data[55:48] <= 8'h02
      && msg_frame_out.data[7:0] <= 8'h01)
    else $error("status byte out of range");
  AST_BCD: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    msg_valid_out && msg_frame_out.id == `RSC_ID_SW_VERSION |->
      msg_frame_out.data[3:0] <= 4'h9 && msg_frame_out.data[19:16] <= 4'h9)
    else $error("date digit not decimal");
  AST_VER_TAIL: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    req[2] && !is_diag(dev_mode) |=> snap_reg[2][63:56] == 8'hff)
    else $error("version byte 7 not filled");
  AST_IND_DIS: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    alarm_dis_reg[0] ##1 alarm_dis_reg[0] |-> alarm_status_out[1:0] == 2'b11)
    else $error("disabled indicator not reported");
  AST_WAIT: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    bus_take |=> avs_waitrequest_out)
    else $error("waitrequest not raised after access");
endmodule

/* test/rsc_can_sink.sv */
// Frame consumer standing in for the monitoring nodes on the bus
`timescale 1ns/1ps
module rsc_can_sink (
  input  wire logic                clk_in,
  input  wire logic                resetn_in,
  input  wire logic                slow_in,
  input  wire logic                valid_in,
  input  wire rsc_pkg::rsc_frame_t frame_in,
  output logic                     ready_out
);
  rsc_pkg::rsc_frame_t got[$];
  logic [2:0]          stall_reg;

  // Slow mode takes one frame in eight cycles, so queued frames must stand
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stall_reg <= 3'h0;
      ready_out <= 1'b0;
    end else begin
      stall_reg <= stall_reg + 3'h1;
      ready_out <= !slow_in || (stall_reg == 3'h7);
    end
  end

  always @(posedge clk_in) begin
    if (resetn_in && valid_in && ready_out) begin
      got.push_back(frame_in);
    end
  end
endmodule

/* test/testbench.sv */
// Self-checking bench for the regulator status payload framer
`timescale 1ns/1ps
module testbench;
  logic                clk_sys_in;
  logic                resetn_in;
  logic [5:0]          addr;
  logic                rd;
  logic                wr;
  logic [31:0]         wdata;
  logic [3:0]          be;
  logic [31:0]         rdata;
  logic                wait_req;
  logic [10:0]         alarm;
  logic [10:0]         fault;
  logic [21:0]         status;
  rsc_pkg::rsc_frame_t frame;
  logic                valid;
  logic                ready;
  logic                slow;
  logic [31:0]         q;
  int                  failures;
  int                  checks;

  rsc_framer uut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
    .alarm_active_in(alarm), .fault_active_in(fault), .alarm_status_out(status),
    .msg_frame_out(frame), .msg_valid_out(valid), .msg_ready_in(ready));

  rsc_can_sink sink (.clk_in(clk_sys_in), .resetn_in(resetn_in), .slow_in(slow),
    .valid_in(valid), .frame_in(frame), .ready_out(ready));

  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  task automatic summarize;
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request stands until the rising edge that sees waitrequest low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] r, input logic [3:0] e = 4'hf);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    be <= e;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      failures++;
      summarize();
    end
  endtask

  task automatic drain(input int k);
    int n;
    n = 0;
    while (sink.got.size() < k && n < 400) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= 400) begin
      failures++;
      summarize();
    end
  endtask

  task automatic all_messages;
    logic [37:0] setup [12] = '{{6'h04, 32'h1}, {6'h08, 32'ha1b2}, {6'h0c, 32'hc3d4},
      {6'h10, 32'h8e9f}, {6'h14, 32'h1388}, {6'h18, 32'h708}, {6'h1c, 32'hfa},
      {6'h20, 32'hfffb}, {6'h24, 32'h1f0c07d6}, {6'h28, 32'h5a38220c},
      {6'h2c, 32'h70233}, {6'h30, 32'h1234}};
    slow <= 1'b1;
    foreach (setup[i]) bus(1'b1, setup[i][37:32], setup[i][31:0], q);
    bus(1'b1, 6'h00, 32'hf, q);
    // Late field write while frames wait behind a stalled consumer
    bus(1'b1, 6'h14, 32'h0, q);
    drain(4);
    chk(sink.got[0], {16'hff30, 64'h8e9fc3d4a1b2ff01});
    chk(sink.got[1], {16'hff2a, 64'hfffb00fa07081388});
    chk(sink.got[2], {16'hff5a, 64'hff38220c31122006});
    chk(sink.got[3], {16'hff5b, 64'h0702030001123401});
  endtask

  task automatic diag_version;
    slow <= 1'b0;
    bus(1'b1, 6'h2c, 32'he0233, q);
    bus(1'b1, 6'h00, 32'h4, q);
    drain(5);
    chk(sink.got[4], {16'hff5a, 64'h5a38220c31122006});
    bus(1'b0, 6'h00, 32'h0, q);
    chk({48'h0, q}, 80'h0);
    // Single-lane write must leave the other revision bytes alone
    bus(1'b1, 6'h28, 32'h1100_0000, q, 4'h8);
    bus(1'b0, 6'h28, 32'h0, q);
    chk({48'h0, q}, {48'h0, 32'h1138220c});
    bus(1'b0, 6'h3c, 32'h0, q);
    chk({48'h0, q}, 80'h0);
  endtask

  task automatic indicators;
    bus(1'b1, 6'h34, 32'h5, q);
    alarm <= 11'h008;
    fault <= 11'h002;
    repeat (2) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk({58'h0, status}, {58'h0, 22'h7b});
    @(posedge clk_sys_in);
    alarm <= 11'h000;
    fault <= 11'h7ff;
    repeat (2) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk({58'h0, status}, {58'h0, 22'h2aaabb});
  endtask

  initial begin
    resetn_in = 1'b0;
    addr = 6'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    be = 4'hf;
    alarm = 11'h000;
    fault = 11'h000;
    slow = 1'b0;
    failures = 0;
    checks = 0;
    repeat (20) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    all_messages();
    diag_version();
    indicators();
    summarize();
  end
endmodule
